// File: verilog/iotp_pkg.sv
package iotp_pkg;

    localparam int unsigned ADR_W          = 8;
    localparam int unsigned DAT_W          = 32;
    localparam logic [7:0]  OFF_TUNE       = 8'h00;
    localparam logic [7:0]  OFF_CTRL       = 8'h04;
    localparam logic [7:0]  OFF_STAT       = 8'h08;

    localparam int unsigned TUNE_LFSEL_BIT = 7;
    localparam int unsigned TUNE_MULT_BIT  = 6;
    localparam int unsigned TUNE_TRIM_LSB  = 0;
    localparam int unsigned TRIM_W         = 5;
    localparam logic [7:0]  TUNE_RESET     = 8'h00;

    localparam int unsigned CTRL_SCS_LSB   = 0;
    localparam int unsigned CTRL_FSEL_LSB  = 4;
    localparam logic [2:0]  FSEL_RESET     = 3'h4;
    localparam logic [1:0]  SCS_RESET      = 2'h0;

    localparam int unsigned STAT_CFG_LSB   = 0;
    localparam int unsigned STAT_MULT_BIT  = 4;
    localparam int unsigned STAT_FOSC_BIT  = 5;
    localparam int unsigned STAT_SEC_BIT   = 6;

    localparam logic [3:0]  CFG_INT_A      = 4'h9;
    localparam logic [3:0]  CFG_INT_B      = 4'h8;
    localparam logic [2:0]  FSEL_8M        = 3'h7;
    localparam logic [2:0]  FSEL_4M        = 3'h6;
    localparam logic [2:0]  FSEL_LF        = 3'h0;
    localparam logic [1:0]  SCS_PRIMARY    = 2'h0;
    localparam logic [1:0]  SCS_SECONDARY  = 2'h1;
    localparam logic [7:0]  LF_DIV_MASK    = 8'hff;

    localparam int unsigned SETTLE_TIME_MS = 1;
    localparam int unsigned CLK_FREQ_KHZ   = 200000;
    localparam int unsigned SETTLE_CYCLES  = SETTLE_TIME_MS * CLK_FREQ_KHZ;
    localparam int unsigned TRIM_STEPS     = 32;

    typedef enum logic [1:0] {
        SLEW_IDLE = 2'b01,
        SLEW_MOVE = 2'b10
    } iotp_slew_type;

    function automatic logic iotp_mult_allowed(input logic [3:0] cfg, input logic [2:0] fsel);
        iotp_mult_allowed = ((cfg == CFG_INT_A) || (cfg == CFG_INT_B)) &&
                            ((fsel == FSEL_8M) || (fsel == FSEL_4M));
    endfunction : iotp_mult_allowed

    // Postscaler mask: divide by mask+1
    function automatic logic [7:0] iotp_div_mask(input logic [2:0] fsel);
        iotp_div_mask = (fsel == FSEL_LF) ? LF_DIV_MASK : 8'(8'h7f >> fsel);
    endfunction : iotp_div_mask

endpackage : iotp_pkg

// File: verilog/iotp_tick_if.sv
`timescale 1ns/10ps
interface iotp_tick_if;
    logic       fast_tick;
    logic       slow_tick;
    logic [2:0] freq_sel;
    logic       lf_sel;
    logic       int_tick;
    logic       fast_osc_en;

    modport ctrl  (output fast_tick, output slow_tick, output freq_sel, output lf_sel,
                   input int_tick, input fast_osc_en);
    modport scale (input fast_tick, input slow_tick, input freq_sel, input lf_sel,
                   output int_tick, output fast_osc_en);
endinterface : iotp_tick_if

// File: verilog/iotp_postscale.sv
`timescale 1ns/10ps
module iotp_postscale
    import iotp_pkg::*;
(
    input  wire logic   clock_i,
    input  wire logic   rst_n_i,
    input  wire logic   ce_i,
    iotp_tick_if.scale  tk
);

    logic [7:0] div_cnt_q;
    logic       int_tick_q;
    logic       fosc_en_q;
    logic [7:0] mask;
    logic       use_slow;

    assign mask     = iotp_div_mask(tk.freq_sel);
    assign use_slow = (tk.freq_sel == FSEL_LF) && !tk.lf_sel;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_cnt_q <= 8'h00;
        end else if (ce_i && tk.fast_tick) begin
            div_cnt_q <= 8'(div_cnt_q + 8'h01);
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            int_tick_q <= 1'b0;
        end else if (ce_i) begin
            if (use_slow) begin
                int_tick_q <= tk.slow_tick;
            end else begin
                int_tick_q <= tk.fast_tick && ((div_cnt_q & mask) == mask);
            end
        end
    end

    // Fast oscillator idles when the slow RC alone feeds the low range
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fosc_en_q <= 1'b1;
        end else if (ce_i) begin
            fosc_en_q <= !use_slow;
        end
    end

    assign tk.int_tick    = int_tick_q;
    assign tk.fast_osc_en = fosc_en_q;

    property p_direct_8m;
        @(posedge clock_i) disable iff (!rst_n_i)
        (ce_i && tk.freq_sel == FSEL_8M && tk.fast_tick) |=> tk.int_tick;
    endproperty
    a_direct_8m: assert property (p_direct_8m)
        else $error("8 MHz select did not pass fast tick");

    property p_lf_slow;
        @(posedge clock_i) disable iff (!rst_n_i)
        (ce_i && use_slow) |=> (tk.int_tick == $past(tk.slow_tick));
    endproperty
    a_lf_slow: assert property (p_lf_slow)
        else $error("Low range not taken from slow RC");

endmodule : iotp_postscale

// File: verilog/iotp_ctrl.sv
// Design decisions made here: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps
module iotp_ctrl
    import iotp_pkg::*;
#(
    parameter int unsigned SETTLE_CYC = SETTLE_CYCLES
) (
    input  wire logic               clock_i,
    input  wire logic               rst_n_i,
    input  wire logic               ce_i,
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [ADR_W-1:0]   wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [DAT_W-1:0]   wb_dat_i,
    output logic      [DAT_W-1:0]   wb_dat_o,
    output logic                    wb_ack_o,
    input  wire logic [3:0]         primary_osc_config_i,
    input  wire logic               fast_osc_i,
    input  wire logic               slow_rc_i,
    input  wire logic               pm_mode_i,
    output logic      [TRIM_W-1:0]  trim_field_o,
    output logic                    fast_osc_enable_o,
    output logic                    multiplier_on_o,
    output logic                    internal_clk_tick_o,
    output logic                    watchdog_clk_tick_o,
    output logic      [1:0]         dev_clk_src_o,
    output logic                    secondary_osc_run_o,
    output logic      [2:0]         internal_freq_select_o
);

    localparam int unsigned STEP_CYC = SETTLE_CYC / TRIM_STEPS;
    localparam int unsigned STEP_W   = $clog2(STEP_CYC + 1);

    // Fewer than one cycle per step cannot meet the settle bound
    if (STEP_CYC < 1) begin : g_settle_chk
        $error("SETTLE_CYC must be at least 32");
    end

    // Pin synchronisers, third stage only for edge detection
    logic [2:0]  fast_sync_q;
    logic [2:0]  slow_sync_q;
    logic [3:0]  cfg_meta_q;
    logic [3:0]  cfg_q;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fast_sync_q <= 3'h0;
            slow_sync_q <= 3'h0;
            cfg_meta_q  <= 4'h0;
            cfg_q       <= 4'h0;
        end else if (ce_i) begin
            fast_sync_q <= {fast_sync_q[1:0], fast_osc_i};
            slow_sync_q <= {slow_sync_q[1:0], slow_rc_i};
            cfg_meta_q  <= primary_osc_config_i;
            cfg_q       <= cfg_meta_q;
        end
    end

    logic fast_tick;
    logic slow_tick;

    assign fast_tick = fast_sync_q[1] && !fast_sync_q[2];
    assign slow_tick = slow_sync_q[1] && !slow_sync_q[2];

    // Register file
    logic                lfsel_q;
    logic                mult_en_q;
    logic [TRIM_W-1:0]   trim_tgt_q;
    logic [2:0]          fsel_q;
    logic [1:0]          scs_q;
    logic                ack_q;
    logic [DAT_W-1:0]    rdat_q;
    logic                wr_stb;
    logic                mult_ok;

    assign mult_ok = iotp_mult_allowed(cfg_q, fsel_q);
    assign wr_stb  = ce_i && wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0];

    // One wait cycle, then ack for one cycle
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_q <= 1'b0;
        end else if (ce_i) begin
            ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lfsel_q    <= TUNE_RESET[TUNE_LFSEL_BIT];
            trim_tgt_q <= TUNE_RESET[TUNE_TRIM_LSB +: TRIM_W];
        end else if (wr_stb && wb_adr_i == OFF_TUNE) begin
            lfsel_q    <= wb_dat_i[TUNE_LFSEL_BIT];
            trim_tgt_q <= wb_dat_i[TUNE_TRIM_LSB +: TRIM_W];
        end
    end

    // Enable drops as soon as its conditions fail; writes then ignored
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mult_en_q <= TUNE_RESET[TUNE_MULT_BIT];
        end else if (ce_i) begin
            if (!mult_ok) begin
                mult_en_q <= 1'b0;
            end else if (wr_stb && wb_adr_i == OFF_TUNE) begin
                mult_en_q <= wb_dat_i[TUNE_MULT_BIT];
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fsel_q <= FSEL_RESET;
            scs_q  <= SCS_RESET;
        end else if (wr_stb && wb_adr_i == OFF_CTRL) begin
            fsel_q <= wb_dat_i[CTRL_FSEL_LSB +: 3];
            scs_q  <= wb_dat_i[CTRL_SCS_LSB +: 2];
        end
    end

    // Read data latched with ack; unmapped reads return zero
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdat_q <= '0;
        end else if (ce_i && wb_cyc_i && wb_stb_i && !ack_q) begin
            rdat_q <= '0;
            case (wb_adr_i)
                OFF_TUNE: begin
                    rdat_q[TUNE_LFSEL_BIT]             <= lfsel_q;
                    rdat_q[TUNE_MULT_BIT]              <= mult_en_q && mult_ok;
                    rdat_q[TUNE_TRIM_LSB +: TRIM_W]    <= trim_tgt_q;
                end
                OFF_CTRL: begin
                    rdat_q[CTRL_FSEL_LSB +: 3]         <= fsel_q;
                    rdat_q[CTRL_SCS_LSB +: 2]          <= scs_q;
                end
                OFF_STAT: begin
                    rdat_q[STAT_CFG_LSB +: 4]          <= cfg_q;
                    rdat_q[STAT_MULT_BIT]              <= multiplier_on_o;
                    rdat_q[STAT_FOSC_BIT]              <= fast_osc_enable_o;
                    rdat_q[STAT_SEC_BIT]               <= secondary_osc_run_o;
                end
                default: begin
                    rdat_q <= '0;
                end
            endcase
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // Trim slews one code per step so 31 codes fit in the settle time
    iotp_slew_type       slew_q;
    logic [STEP_W-1:0]   step_cnt_q;
    logic [TRIM_W-1:0]   trim_app_q;
    logic                step_hit;
    logic                trim_up;

    assign step_hit = (step_cnt_q == STEP_W'(STEP_CYC - 1));
    assign trim_up  = $signed(trim_tgt_q) > $signed(trim_app_q);

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            slew_q <= SLEW_IDLE;
        end else if (ce_i) begin
            case (slew_q)
                SLEW_IDLE: begin
                    if (trim_tgt_q != trim_app_q) begin
                        slew_q <= SLEW_MOVE;
                    end
                end
                SLEW_MOVE: begin
                    if (trim_tgt_q == trim_app_q) begin
                        slew_q <= SLEW_IDLE;
                    end
                end
                default: begin
                    slew_q <= SLEW_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            step_cnt_q <= '0;
        end else if (ce_i) begin
            if (slew_q != SLEW_MOVE || step_hit) begin
                step_cnt_q <= '0;
            end else begin
                step_cnt_q <= STEP_W'(step_cnt_q + 1'b1);
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            trim_app_q <= TUNE_RESET[TUNE_TRIM_LSB +: TRIM_W];
        end else if (ce_i && slew_q == SLEW_MOVE && step_hit && trim_tgt_q != trim_app_q) begin
            if (trim_up) begin
                trim_app_q <= TRIM_W'(trim_app_q + 1'b1);
            end else begin
                trim_app_q <= TRIM_W'(trim_app_q - 1'b1);
            end
        end
    end

    // Only the fast oscillator receives the trim
    assign trim_field_o = trim_app_q;

    // Postscaler
    iotp_tick_if tk_if ();

    assign tk_if.fast_tick = fast_tick;
    assign tk_if.slow_tick = slow_tick;
    assign tk_if.freq_sel  = fsel_q;
    assign tk_if.lf_sel    = lfsel_q;

    iotp_postscale u_postscale (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .ce_i    (ce_i),
        .tk      (tk_if.scale)
    );

    assign internal_clk_tick_o = tk_if.int_tick;
    assign fast_osc_enable_o   = tk_if.fast_osc_en;

    // Source and support outputs
    logic mult_on_q;
    logic wdt_tick_q;
    logic sec_run_q;
    logic [1:0] src_q;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mult_on_q  <= 1'b0;
            wdt_tick_q <= 1'b0;
            sec_run_q  <= 1'b0;
            src_q      <= SCS_RESET;
        end else if (ce_i) begin
            mult_on_q  <= mult_en_q && mult_ok;
            wdt_tick_q <= slow_tick;
            src_q      <= scs_q;
            // Secondary keeps running through power-managed modes
            sec_run_q  <= (scs_q == SCS_SECONDARY) || (sec_run_q && pm_mode_i);
        end
    end

    assign multiplier_on_o        = mult_on_q;
    assign watchdog_clk_tick_o    = wdt_tick_q;
    assign dev_clk_src_o          = src_q;
    assign secondary_osc_run_o    = sec_run_q;
    assign internal_freq_select_o = fsel_q;

    property p_mult_gate;
        @(posedge clock_i) disable iff (!rst_n_i)
        (ce_i && !mult_ok) |=> !multiplier_on_o;
    endproperty
    a_mult_gate: assert property (p_mult_gate)
        else $error("Multiplier on while not allowed");

    property p_mult_ignore;
        @(posedge clock_i) disable iff (!rst_n_i)
        (wr_stb && wb_adr_i == OFF_TUNE && !mult_ok) |=> !mult_en_q;
    endproperty
    a_mult_ignore: assert property (p_mult_ignore)
        else $error("Multiplier enable write not ignored");

    property p_mult_sw;
        @(posedge clock_i) disable iff (!rst_n_i)
        (ce_i && mult_ok && wr_stb && wb_adr_i == OFF_TUNE && wb_dat_i[TUNE_MULT_BIT])
            ##1 (ce_i && mult_ok) |=> multiplier_on_o;
    endproperty
    a_mult_sw: assert property (p_mult_sw)
        else $error("Multiplier did not start after enable");

    property p_trim_write;
        @(posedge clock_i) disable iff (!rst_n_i)
        (wr_stb && wb_adr_i == OFF_TUNE) |=> (trim_tgt_q == $past(wb_dat_i[TRIM_W-1:0]));
    endproperty
    a_trim_write: assert property (p_trim_write)
        else $error("Trim field not stored");

    property p_trim_slew;
        @(posedge clock_i) disable iff (!rst_n_i)
        (trim_field_o != $past(trim_field_o)) |-> $past(step_hit && slew_q == SLEW_MOVE);
    endproperty
    a_trim_slew: assert property (p_trim_slew)
        else $error("Trim moved outside a step");

    property p_trim_dir;
        @(posedge clock_i) disable iff (!rst_n_i)
        (ce_i && slew_q == SLEW_MOVE && step_hit && trim_up)
            |=> (trim_field_o == TRIM_W'($past(trim_field_o) + 1'b1));
    endproperty
    a_trim_dir: assert property (p_trim_dir)
        else $error("Signed trim stepped the wrong way");

    property p_wdt;
        @(posedge clock_i) disable iff (!rst_n_i)
        ce_i |=> (watchdog_clk_tick_o == $past(slow_tick));
    endproperty
    a_wdt: assert property (p_wdt)
        else $error("Watchdog tick not from slow RC");

    property p_ack_pulse;
        @(posedge clock_i) disable iff (!rst_n_i)
        (ce_i && wb_ack_o) |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("Ack held for more than one cycle");

    property p_ack_wait;
        @(posedge clock_i) disable iff (!rst_n_i)
        (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
    endproperty
    a_ack_wait: assert property (p_ack_wait)
        else $error("Register access not answered after one wait cycle");

    // With lfsel_q clear the slow RC alone feeds the low range, so the fast oscillator may stop
    property p_fosc_off;
        @(posedge clock_i) disable iff (!rst_n_i)
        (ce_i && fsel_q == FSEL_LF && !lfsel_q) |=> !fast_osc_enable_o;
    endproperty
    a_fosc_off: assert property (p_fosc_off)
        else $error("Fast oscillator kept on for slow RC low range");

    property p_sec_run;
        @(posedge clock_i) disable iff (!rst_n_i)
        (ce_i && scs_q == SCS_SECONDARY) |=> secondary_osc_run_o;
    endproperty
    a_sec_run: assert property (p_sec_run)
        else $error("Secondary oscillator not running when selected");

endmodule : iotp_ctrl

// File: verification/iotp_tb.sv
`timescale 1ns/10ps
module tb;
    import iotp_pkg::*;

    localparam int unsigned SETTLE = 64;

    logic              clock_i              = 1'b0;
    logic              rst_n_i              = 1'b0;
    logic              wb_cyc_i             = 1'b0;
    logic              wb_stb_i             = 1'b0;
    logic              wb_we_i              = 1'b0;
    logic [ADR_W-1:0]  wb_adr_i             = '0;
    logic [3:0]        wb_sel_i             = 4'h0;
    logic [DAT_W-1:0]  wb_dat_i             = '0;
    logic [3:0]        primary_osc_config_i = 4'h0;
    logic              fast_osc_i           = 1'b0;
    logic              slow_rc_i            = 1'b0;
    logic              pm_mode_i            = 1'b0;
    logic [DAT_W-1:0]  wb_dat_o;
    logic              wb_ack_o;
    logic [TRIM_W-1:0] trim_field_o;
    logic              fast_osc_enable_o;
    logic              multiplier_on_o;
    logic              internal_clk_tick_o;
    logic              watchdog_clk_tick_o;
    logic [1:0]        dev_clk_src_o;
    logic              secondary_osc_run_o;
    logic [2:0]        internal_freq_select_o;
    logic [7:0]        osc_cnt = 8'h00;
    int                int_cnt = 0;
    int                wd_cnt  = 0;
    int                num_errors = 0;
    int                n_checks   = 0;

    iotp_ctrl #(.SETTLE_CYC(SETTLE)) dut_u (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .primary_osc_config_i(primary_osc_config_i), .fast_osc_i(fast_osc_i),
        .slow_rc_i(slow_rc_i), .pm_mode_i(pm_mode_i), .trim_field_o(trim_field_o),
        .fast_osc_enable_o(fast_osc_enable_o), .multiplier_on_o(multiplier_on_o),
        .internal_clk_tick_o(internal_clk_tick_o),
        .watchdog_clk_tick_o(watchdog_clk_tick_o), .dev_clk_src_o(dev_clk_src_o),
        .secondary_osc_run_o(secondary_osc_run_o),
        .internal_freq_select_o(internal_freq_select_o)
    );

    always #2.5 clock_i = ~clock_i;

    // Fast source: 4-cycle period; slow RC: 32-cycle period
    always @(posedge clock_i) begin
        osc_cnt    <= osc_cnt + 8'h01;
        fast_osc_i <= osc_cnt[1];
        slow_rc_i  <= osc_cnt[4];
        if (internal_clk_tick_o === 1'b1) int_cnt <= int_cnt + 1;
        if (watchdog_clk_tick_o === 1'b1) wd_cnt <= wd_cnt + 1;
    end

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Ack is sampled at the rising edge at which the write lands and data is taken
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q);
        @(posedge clock_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        do begin
            @(posedge clock_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        // Outputs launched at the ack edge settle before callers look
        @(negedge clock_i);
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, 4'hf, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        wb(1'b0, a, 32'h0, 4'hf, q);
    endtask : rd

    task automatic measure(output int ni, output int nw);
        int a;
        int b;
        @(negedge clock_i);
        a = int_cnt;
        b = wd_cnt;
        repeat (2048) @(negedge clock_i);
        ni = int_cnt - a;
        nw = wd_cnt - b;
    endtask : measure

    function automatic logic near(input int n, input int e);
        near = (n >= e - 1) && (n <= e + 1);
    endfunction : near

    logic [31:0] q;
    int          ni;
    int          nw;
    logic        ok;
    logic [3:0]  cfgs [3] = '{4'h0, 4'h8, 4'h9};
    logic [2:0]  fsels[4] = '{3'h7, 3'h6, 3'h5, 3'h0};

    initial begin
        repeat (8) @(posedge clock_i);
        rst_n_i <= 1'b1;
        rd(OFF_TUNE, q);
        check("tune reset", q, 32'h0);
        rd(OFF_CTRL, q);
        check("ctrl reset", q, 32'h40);
        check("trim reset", trim_field_o, 32'h0);
        $display("test reset done");

        wr(OFF_TUNE, 32'h03);
        @(negedge clock_i);
        check("trim no jump", trim_field_o, 32'h0);
        repeat (SETTLE) @(negedge clock_i);
        check("trim up", trim_field_o, 32'h03);
        wr(OFF_TUNE, 32'h10);
        check("trim slew", trim_field_o !== 5'h10, 32'h1);
        repeat (SETTLE) @(negedge clock_i);
        check("trim min", trim_field_o, 32'h10);
        measure(ni, nw);
        check("slow rc untouched", near(nw, 64), 32'h1);
        wr(OFF_TUNE, 32'h2f);
        rd(OFF_TUNE, q);
        check("tune bit5", q, 32'h0f);
        repeat (SETTLE) @(negedge clock_i);
        check("trim max", trim_field_o, 32'h0f);
        // Interval measured too long: software steps the trim down by one
        rd(OFF_TUNE, q);
        wr(OFF_TUNE, {27'h0, 5'(q[4:0] - 5'h01)});
        repeat (SETTLE) @(negedge clock_i);
        check("trim down", trim_field_o, 32'h0e);
        wr(OFF_TUNE, 32'h00);
        $display("test trim done");

        foreach (cfgs[i]) begin
            @(posedge clock_i);
            primary_osc_config_i <= cfgs[i];
            repeat (4) @(posedge clock_i);
            foreach (fsels[j]) begin
                ok = (cfgs[i] != 4'h0) && (fsels[j] inside {3'h7, 3'h6});
                wr(OFF_CTRL, {25'h0, fsels[j], 4'h0});
                check("freq sel", internal_freq_select_o, fsels[j]);
                wr(OFF_TUNE, 32'h40);
                rd(OFF_TUNE, q);
                check("mult bit", q, ok ? 32'h40 : 32'h0);
                check("mult run", multiplier_on_o, ok);
                if (ok) begin
                    wr(OFF_CTRL, 32'h50);
                    repeat (2) @(negedge clock_i);
                    check("mult drop", multiplier_on_o, 32'h0);
                    wr(OFF_CTRL, {25'h0, fsels[j], 4'h0});
                    rd(OFF_TUNE, q);
                    check("mult stays off", q, 32'h0);
                end
                wr(OFF_TUNE, 32'h00);
            end
        end
        $display("test multiplier done");

        for (int s = 7; s >= 1; s--) begin
            wr(OFF_CTRL, 32'(s << 4));
            measure(ni, nw);
            check("postscale", near(ni, 512 >> (7 - s)), 32'h1);
        end
        wr(OFF_CTRL, 32'h00);
        repeat (2) @(negedge clock_i);
        check("fast off", fast_osc_enable_o, 32'h0);
        measure(ni, nw);
        check("lf from rc", near(ni, 64), 32'h1);
        check("wd from rc", near(nw, 64), 32'h1);
        wr(OFF_TUNE, 32'h80);
        repeat (2) @(negedge clock_i);
        check("fast on", fast_osc_enable_o, 32'h1);
        measure(ni, nw);
        check("lf div256", near(ni, 2), 32'h1);
        check("wd still rc", near(nw, 64), 32'h1);
        wr(OFF_TUNE, 32'h00);
        $display("test low freq done");

        wr(OFF_STAT, 32'hff);
        rd(OFF_STAT, q);
        check("status ro", q, 32'h09);
        wr(8'h0c, 32'hff);
        rd(8'h0c, q);
        check("unmapped", q, 32'h0);
        wb(1'b1, OFF_TUNE, 32'h1f, 4'he, q);
        rd(OFF_TUNE, q);
        check("sel0 low", q, 32'h0);
        $display("test bus done");

        for (int s = 0; s < 4; s++) begin
            wr(OFF_CTRL, 32'h40 | 32'(s));
            repeat (2) @(negedge clock_i);
            check("clk src", dev_clk_src_o, 32'(s));
            check("sec run", secondary_osc_run_o, 32'(s == 1));
        end
        wr(OFF_CTRL, 32'h41);
        @(posedge clock_i);
        pm_mode_i <= 1'b1;
        wr(OFF_CTRL, 32'h40);
        repeat (2) @(negedge clock_i);
        check("sec in pm", secondary_osc_run_o, 32'h1);
        @(posedge clock_i);
        pm_mode_i <= 1'b0;
        repeat (3) @(negedge clock_i);
        check("sec off", secondary_osc_run_o, 32'h0);
        $display("test clock source done");
        end_of_test();
    end

    initial begin
        // Roughly 2.4 times the expected run length
        #250000;
        num_errors++;
        end_of_test();
    end

endmodule : tb
